/* File: logic/dpc_pkg.sv */
package dpc_pkg;

    // ********************************
    // register map (32-bit registers, byte offsets)
    // ********************************
    localparam logic [7:0] DPC_REG_CTRL = 8'h00;
    localparam logic [7:0] DPC_REG_CLKCFG = 8'h04;
    localparam logic [7:0] DPC_REG_STATUS = 8'h08;
    localparam logic [7:0] DPC_REG_TDMDIV = 8'h0c;
    localparam logic [7:0] DPC_REG_DECODE = 8'h10;

    // ********************************
    // field positions
    // ********************************
    localparam int DPC_CTRL_IDLE_REQ = 0;
    localparam int DPC_CTRL_STOP_REQ = 1;
    localparam int DPC_CTRL_SOFT_RST = 2;
    localparam int DPC_CFG_PRE_LSB = 0;
    localparam int DPC_CFG_MUL_LSB = 2;
    localparam int DPC_CFG_POST = 8;
    localparam int DPC_CFG_CPU_LSB = 9;
    localparam int DPC_CFG_SRC = 12;
    localparam int DPC_CFG_TDM_EXT = 13;

    // ********************************
    // reset values
    // ********************************
    localparam logic [31:0] DPC_CLKCFG_RST = 32'h0000_0000;
    localparam logic [7:0] DPC_TDMDIV_RST = 8'h00;

    // ********************************
    // timing
    // ********************************
    localparam int DPC_CLK_MHZ = 200;
    localparam int DPC_SETTLE_US = 200;
    localparam int DPC_SETTLE_CYC = DPC_SETTLE_US * DPC_CLK_MHZ;

    // ********************************
    // address decode constants
    // ********************************
    localparam logic [15:0] DPC_PROM_LO = 16'h0000;
    localparam logic [15:0] DPC_PROM_HI = 16'hefff;
    localparam logic [15:0] DPC_MMR_LO = 16'h2000;
    localparam logic [15:0] DPC_MMR_HI = 16'h2fff;
    localparam logic [15:0] DPC_EMU_LO = 16'hf7f0;
    localparam logic [15:0] DPC_EMU_HI = 16'hf7ff;
    localparam logic [15:0] DPC_APP_LO = 16'h0020;
    localparam logic [15:0] DPC_APP_HI = 16'hebbf;

    typedef enum logic [2:0] {
        DPC_ACTIVE = 3'b001,
        DPC_IDLE   = 3'b010,
        DPC_STOP   = 3'b100
    } dpc_mode_e;

    typedef struct packed {
        logic        resume;
        logic        irq;
        logic        ext_irq;
        logic        debug_rst;
    } dpc_wake_s;

    typedef struct packed {
        logic        dsp_clk_en;
        logic        dsp_core_pwr;
        logic        pll_pwr;
        logic        pll_src_usb;
        logic [1:0]  pre_div;
        logic [5:0]  pll_mul;
        logic        post_div2;
    } dpc_clkctl_s;

endpackage

/* File: logic/dpc_div.sv */
`timescale 1ns/1ps
`default_nettype none
// integer divider producing a one-cycle enable every (ratio+1) input ticks
module dpc_div #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // control
    input wire logic tick_in,
    input wire logic [W-1:0] ratio,
    // output
    output logic tick_out
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic pulse;
    } dpc_div_s;

    dpc_div_s st_ff;
    dpc_div_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (tick_in) begin
            if (st_ff.cnt >= ratio) begin
                nxt_st.cnt = '0;
                nxt_st.pulse = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_out = st_ff.pulse;
endmodule // dpc_div
`default_nettype wire

/* File: logic/dpc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - modes ACTIVE, IDLE, STOP; core off otherwise
// - PLL stays powered in IDLE
// - STOP powers PLL down; exit inserts settle delay
// - IDLE exits on interrupt or any reset
// - STOP exits on resume, external irq, resets
// - STOP exits to ACTIVE; resume keeps state
// - internal TDM clock divides master clock
// - external TDM clock comes from pins
// - CPU clock is master divided 1/2/4/8/16
// - DSP path pre-divide, PLL multiply, post-divide
// - PLL reference selectable, resets to master
// - block program ROM data reads
// - peripheral registers at 0x2000-0x2FFF
// - emulator registers at 0xF7F0-0xF7FF
// - application ROM location chosen by pin
// - each peripheral gets its 256-word window
module dpc_top
    import dpc_pkg::*;
#(
    parameter int SETTLE_CYC = DPC_SETTLE_CYC,
    parameter int TDM_W = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // wake sources (pins, asynchronous)
    input wire logic dsp_resume_signal,
    input wire logic dsp_irq,
    input wire logic ext_irq,
    input wire logic debug_port_rst,
    // tdm pins and ROM strap
    input wire logic tdm_ext_clk_pin,
    input wire logic prog_rom_location_select,
    // dsp address decode request
    input wire logic [15:0] dsp_addr,
    input wire logic dsp_prog_space,
    input wire logic dsp_movp_rd,
    // power and clock control outputs
    output dpc_clkctl_s clk_ctl,
    output logic [2:0] dsp_mode,
    output logic dsp_regs_keep,
    output logic dsp_soft_rst,
    output logic cpu_clk_en,
    output logic tdm_clk_en,
    // decode outputs
    output logic dec_mmr_sel,
    output logic [3:0] dec_mmr_block,
    output logic dec_emu_sel,
    output logic dec_app_rom_onchip,
    output logic dec_app_rom_offchip,
    output logic dec_prom_block
);
    localparam int CNT_W = $clog2(SETTLE_CYC + 1);
    // faster clock: raise SETTLE_CYC

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        // power sequencer
        dpc_mode_e mode;
        logic settling;
        logic [CNT_W-1:0] settle_cnt;
        logic resumed;
        logic soft_rst;

        // software registers
        logic [31:0] clkcfg;
        logic [TDM_W-1:0] tdm_div;

        // pin synchronisers
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [1:0] tdm_sync;
        logic tdm_prev;

        // clock enables
        logic [4:0] cpu_cnt;
        logic cpu_en;
        logic tdm_en;

        // bus side
        logic ack;
        logic [31:0] rdata;

        // registered decode
        logic prom_blk;
        logic mmr;
        logic [3:0] mmr_blk;
        logic emu;
        logic app_on;
        logic app_off;
        logic rom_sel1;
        logic rom_sel2;
    } dpc_state_s;

    // all state but the tdm divider's in one struct, nxt_st is its next value
    dpc_state_s st_ff;
    dpc_state_s nxt_st;
    logic tdm_int_tick;
    logic wr;
    logic rd;
    logic [3:0] cpu_mask;

    // the registered ack masks the second edge of a request,
    // so one bus cycle never writes twice
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_ff.ack;
    assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !st_ff.ack;

    // internal tdm clock from the master clock
    // tick_in high: counts every master cycle
    dpc_div #(.W(TDM_W)) u_tdm_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .tick_in(1'b1),
        .ratio(st_ff.tdm_div),
        .tick_out(tdm_int_tick)
    );

    // codes above four run undivided rather than stop
    always_comb begin
        case (st_ff.clkcfg[DPC_CFG_CPU_LSB +: 3])
            3'h1: cpu_mask = 4'h1;
            3'h2: cpu_mask = 4'h3;
            3'h3: cpu_mask = 4'h7;
            3'h4: cpu_mask = 4'hf;
            default: cpu_mask = 4'h0;
        endcase
    end

    always_comb begin
        // each field holds unless a later assignment moves it
        nxt_st = st_ff;
        nxt_st.soft_rst = 1'b0;

        // ********************************
        // pin synchronisers
        // ********************************
        // only the second stage is read
        nxt_st.sync1 = {dsp_resume_signal, dsp_irq, ext_irq, debug_port_rst};
        nxt_st.sync2 = st_ff.sync1;

        // edge history starts low like the idle pin
        nxt_st.tdm_sync = {st_ff.tdm_sync[0], tdm_ext_clk_pin};
        nxt_st.tdm_prev = st_ff.tdm_sync[1];

        nxt_st.rom_sel1 = prog_rom_location_select;
        nxt_st.rom_sel2 = st_ff.rom_sel1;

        // ********************************
        // wishbone slave, registered ack after one wait cycle
        // ********************************
        // ack comes the cycle after the request
        nxt_st.ack = wb_cyc_i && wb_stb_i && !st_ff.ack;
        // zero outside the ack cycle
        nxt_st.rdata = '0;

        if (rd) begin
            case (wb_adr_i)
                DPC_REG_CLKCFG: nxt_st.rdata = st_ff.clkcfg;
                DPC_REG_STATUS: nxt_st.rdata = {26'h0, st_ff.resumed, st_ff.settling,
                                                st_ff.clkcfg[DPC_CFG_SRC], st_ff.mode};
                DPC_REG_TDMDIV: nxt_st.rdata = 32'(st_ff.tdm_div);
                DPC_REG_DECODE: nxt_st.rdata = {31'h0, st_ff.rom_sel2};
                default: nxt_st.rdata = '0;
            endcase
        end

        // ********************************
        // power mode sequencer
        // ********************************
        // dsp clock gated while this counts
        if (st_ff.settling) begin
            if (st_ff.settle_cnt == '0) begin
                nxt_st.settling = 1'b0;
            end else begin
                nxt_st.settle_cnt = st_ff.settle_cnt - CNT_W'(1);
            end
        end

        case (st_ff.mode)
            DPC_ACTIVE: begin
                if (wr && wb_adr_i == DPC_REG_CTRL && wb_sel_i[0]) begin
                    // stop wins over idle
                    if (wb_dat_i[DPC_CTRL_STOP_REQ]) begin
                        nxt_st.mode = DPC_STOP;
                    end else if (wb_dat_i[DPC_CTRL_IDLE_REQ]) begin
                        nxt_st.mode = DPC_IDLE;
                    end
                    nxt_st.resumed = 1'b0;
                end
            end

            DPC_IDLE: begin
                // pll kept running: no settle delay
                if (st_ff.sync2[2] || st_ff.sync2[1] || st_ff.sync2[0]) begin
                    nxt_st.mode = DPC_ACTIVE;
                end
            end

            DPC_STOP: begin
                // resume alone keeps register state
                if (st_ff.sync2[3] || st_ff.sync2[1] || st_ff.sync2[0]) begin
                    nxt_st.mode = DPC_ACTIVE;
                    nxt_st.resumed = st_ff.sync2[3];
                    nxt_st.settling = 1'b1;
                    nxt_st.settle_cnt = CNT_W'(SETTLE_CYC - 1);
                end
            end

            default: nxt_st.mode = DPC_ACTIVE;
        endcase
        // soft subsystem reset wakes from any low-power mode
        // dsp_soft_rst pulses for one cycle
        if (wr && wb_adr_i == DPC_REG_CTRL && wb_sel_i[0] && wb_dat_i[DPC_CTRL_SOFT_RST]) begin
            nxt_st.soft_rst = 1'b1;
            nxt_st.resumed = 1'b0;
            // pll was off here as well
            if (st_ff.mode == DPC_STOP) begin
                nxt_st.settling = 1'b1;
                nxt_st.settle_cnt = CNT_W'(SETTLE_CYC - 1);
            end
            nxt_st.mode = DPC_ACTIVE;
        end

        // ********************************
        // clock configuration writes
        // ********************************
        if (wr && wb_adr_i == DPC_REG_CLKCFG) begin
            // byte lanes follow their selects
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    nxt_st.clkcfg[b*8 +: 8] = wb_dat_i[b*8 +: 8];
                end
            end
            // pll running: a switch could glitch
            // reference switch ignored outside STOP
            if (st_ff.mode != DPC_STOP) begin
                nxt_st.clkcfg[DPC_CFG_SRC] = st_ff.clkcfg[DPC_CFG_SRC];
            end
        end

        // tick every ratio+1 cycles
        if (wr && wb_adr_i == DPC_REG_TDMDIV && wb_sel_i[0]) begin
            nxt_st.tdm_div = wb_dat_i[TDM_W-1:0];
        end

        // ********************************
        // cpu and tdm clock enables
        // ********************************

        // low bits pick the cpu rate
        nxt_st.cpu_cnt = st_ff.cpu_cnt + 5'h01;
        nxt_st.cpu_en = ((st_ff.cpu_cnt[3:0] & cpu_mask) == 4'h0);
        // pin needs two cycles per level
        if (st_ff.clkcfg[DPC_CFG_TDM_EXT]) begin
            nxt_st.tdm_en = st_ff.tdm_sync[1] && !st_ff.tdm_prev;
        end else begin
            nxt_st.tdm_en = tdm_int_tick;
        end

        // ********************************
        // dsp address decode, registered
        // ********************************
        // fetches pass, data reads are blocked
        nxt_st.prom_blk = dsp_prog_space && dsp_movp_rd &&
                          dsp_addr <= DPC_PROM_HI;
        nxt_st.mmr = !dsp_prog_space && dsp_addr >= DPC_MMR_LO &&
                     dsp_addr <= DPC_MMR_HI;
        // one of sixteen 256-word windows
        nxt_st.mmr_blk = dsp_addr[11:8];

        nxt_st.emu = !dsp_prog_space && dsp_addr >= DPC_EMU_LO &&
                     dsp_addr <= DPC_EMU_HI;
        // strap picks on or off chip
        nxt_st.app_on = dsp_prog_space && dsp_addr >= DPC_APP_LO &&
                        dsp_addr <= DPC_APP_HI && st_ff.rom_sel2;
        nxt_st.app_off = dsp_prog_space && dsp_addr >= DPC_APP_LO &&
                         dsp_addr <= DPC_APP_HI && !st_ff.rom_sel2;
    end

    // sync reset: active, master reference
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            // other fields clear to idle values
            st_ff <= '0;
            st_ff.mode <= DPC_ACTIVE;
            st_ff.clkcfg <= DPC_CLKCFG_RST;
            st_ff.tdm_div <= TDM_W'(DPC_TDMDIV_RST);
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ********************************
    // outputs
    // ********************************
    // ack and read data are flops
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdata;
    assign dsp_mode = st_ff.mode;
    // level, held until the next control register write
    assign dsp_regs_keep = st_ff.resumed;
    assign dsp_soft_rst = st_ff.soft_rst;

    assign cpu_clk_en = st_ff.cpu_en;
    assign tdm_clk_en = st_ff.tdm_en;

    assign dec_prom_block = st_ff.prom_blk;
    assign dec_mmr_sel = st_ff.mmr;
    assign dec_mmr_block = st_ff.mmr_blk;
    assign dec_emu_sel = st_ff.emu;
    assign dec_app_rom_onchip = st_ff.app_on;
    assign dec_app_rom_offchip = st_ff.app_off;

    always_comb begin
        // idle keeps the pll for a fast return
        clk_ctl.pll_pwr = (st_ff.mode != DPC_STOP);
        clk_ctl.dsp_core_pwr = (st_ff.mode == DPC_ACTIVE);
        clk_ctl.dsp_clk_en = (st_ff.mode == DPC_ACTIVE) && !st_ff.settling;
        clk_ctl.pll_src_usb = st_ff.clkcfg[DPC_CFG_SRC];
        // codes pass through unchanged
        clk_ctl.pre_div = st_ff.clkcfg[DPC_CFG_PRE_LSB +: 2];
        clk_ctl.pll_mul = st_ff.clkcfg[DPC_CFG_MUL_LSB +: 6];
        clk_ctl.post_div2 = st_ff.clkcfg[DPC_CFG_POST];
    end
endmodule // dpc_top
`default_nettype wire

/* File: test/dpc_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module dpc_chk
    import dpc_pkg::*;
#(
    parameter int SETTLE_CYC = 20
) (
    // clock, reset and bus
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    // decode request
    input wire logic [15:0] dsp_addr,
    input wire logic dsp_prog_space,
    input wire logic dsp_movp_rd,
    // watched outputs
    input wire dpc_clkctl_s clk_ctl,
    input wire logic [2:0] dsp_mode,
    input wire logic dec_mmr_sel,
    input wire logic [3:0] dec_mmr_block,
    input wire logic dec_emu_sel,
    input wire logic dec_app_rom_onchip,
    input wire logic dec_app_rom_offchip,
    input wire logic dec_prom_block
);
    // ********************************
    // helper state
    // ********************************
    logic [2:0] mode_q_ff;
    logic [15:0] cnt_ff;
    logic [3:0] wr_hist_ff;
    // counts cycles since leaving stop, so the settle window can be bounded with a few cycles of margin
    always_ff @(posedge clk_sys) begin
        // the write lands on the same edge that raises ack, so record the open request
        wr_hist_ff <= {wr_hist_ff[2:0],
                       wb_cyc_i & wb_we_i & !wb_ack_o & (wb_adr_i == DPC_REG_CTRL)};
        if (!rst_n) begin
            mode_q_ff <= DPC_ACTIVE;
            cnt_ff <= 16'h0;
        end else begin
            mode_q_ff <= dsp_mode;
            if (mode_q_ff == DPC_STOP && dsp_mode == DPC_ACTIVE) begin
                cnt_ff <= 16'h1;
            end else if (cnt_ff != 16'h0 && cnt_ff != 16'hffff) begin
                cnt_ff <= cnt_ff + 16'h1;
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_core_off: assert property (dsp_mode != DPC_ACTIVE |-> !clk_ctl.dsp_core_pwr)
        else $error("core powered outside active mode");
    a_idle_pll: assert property (dsp_mode == DPC_IDLE |-> clk_ctl.pll_pwr)
        else $error("pll off in idle");
    a_stop_pll: assert property (dsp_mode == DPC_STOP |-> !clk_ctl.pll_pwr)
        else $error("pll on in stop");
    a_settle_hold: assert property (cnt_ff >= 1 && cnt_ff <= SETTLE_CYC - 2 |-> !clk_ctl.dsp_clk_en)
        else $error("dsp clock enabled during settle");
    a_settle_done: assert property (cnt_ff == SETTLE_CYC + 3 && dsp_mode == DPC_ACTIVE |-> clk_ctl.dsp_clk_en)
        else $error("dsp clock not enabled after settle");
    a_stop_exit: assert property (dsp_mode == DPC_STOP |=> dsp_mode inside {DPC_STOP, DPC_ACTIVE})
        else $error("stop left to a mode other than active");
    a_sleep_req: assert property ($fell(dsp_mode == DPC_ACTIVE) |-> wr_hist_ff != 4'h0)
        else $error("low power entered without request");
    a_prom_dec: assert property (dec_prom_block == $past(dsp_prog_space && dsp_movp_rd && dsp_addr <= DPC_PROM_HI))
        else $error("program rom read block wrong");
    a_mmr_dec: assert property (dec_mmr_sel == $past(!dsp_prog_space && dsp_addr inside {[DPC_MMR_LO:DPC_MMR_HI]}))
        else $error("peripheral select wrong");
    a_mmr_blk: assert property (dec_mmr_sel |-> dec_mmr_block == $past(dsp_addr[11:8]))
        else $error("peripheral window wrong");
    a_emu_dec: assert property (dec_emu_sel == $past(!dsp_prog_space && dsp_addr inside {[DPC_EMU_LO:DPC_EMU_HI]}))
        else $error("emulator select wrong");
    a_app_dec: assert property ((dec_app_rom_onchip | dec_app_rom_offchip) == $past(dsp_prog_space && dsp_addr inside {[DPC_APP_LO:DPC_APP_HI]}))
        else $error("application rom select wrong");
    a_src_rst: assert property ($rose(rst_n) |-> !clk_ctl.pll_src_usb)
        else $error("pll source not master after reset");
    c_idle: cover property (dsp_mode == DPC_IDLE);
    c_settle: cover property (cnt_ff == 16'h1);
    c_prom: cover property (dec_prom_block);
endmodule // dpc_chk
`default_nettype wire

/* File: test/dpc_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpc_cpu_model
    import dpc_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // command from bench
    input wire logic res_go,
    input wire logic [7:0] res_dly,
    // dsp side
    input wire logic [2:0] dsp_mode,
    output logic dsp_resume_signal
);
    logic [7:0] wait_ff;
    logic busy_ff;
    // resume is held until the dsp has left stop; a short pulse could be lost in its sync
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            busy_ff <= 1'b0;
            wait_ff <= 8'h00;
            dsp_resume_signal <= 1'b0;
        end else if (res_go && !busy_ff) begin
            busy_ff <= 1'b1;
            wait_ff <= res_dly;
        end else if (busy_ff && wait_ff != 8'h00) begin
            wait_ff <= wait_ff - 8'h01;
        end else if (busy_ff && !dsp_resume_signal) begin
            dsp_resume_signal <= 1'b1;
        end else if (dsp_resume_signal && dsp_mode != DPC_STOP) begin
            dsp_resume_signal <= 1'b0;
            busy_ff <= 1'b0;
        end
    end
endmodule // dpc_cpu_model
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module testbench;
    import dpc_pkg::*;
    localparam int SETTLE = 20;
    logic clk_sys = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, res_dly = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, v, seed = 32'h425e;
    logic dsp_irq = 1'b0, ext_irq = 1'b0, debug_port_rst = 1'b0, res_go = 1'b0;
    logic tdm_ext_clk_pin = 1'b0, prog_rom_location_select = 1'b1;
    logic [15:0] dsp_addr = 16'h0, a16;
    logic dsp_prog_space = 1'b0, dsp_movp_rd = 1'b0, wb_ack_o, dsp_resume_signal;
    dpc_clkctl_s clk_ctl;
    logic [2:0] dsp_mode;
    logic [3:0] dec_mmr_block;
    logic dsp_regs_keep, dsp_soft_rst, cpu_clk_en, tdm_clk_en, dec_mmr_sel, dec_emu_sel;
    logic dec_app_rom_onchip, dec_app_rom_offchip, dec_prom_block;
    logic [15:0] corner [12] = '{16'h0000, 16'h0020, 16'h1fff, 16'h2000, 16'h2fff, 16'h3000,
        16'hebbf, 16'hebc0, 16'hefff, 16'hf000, 16'hf7f0, 16'hf7ff};
    int err_total = 0, n_checks = 0, cyc_cnt = 0, tdm_cnt = 0, i, j, k, p;
    // the master clock never stops, so wake logic is always clocked
    always #2.5 clk_sys = ~clk_sys;
    dpc_top #(.SETTLE_CYC(SETTLE)) dpc_top_inst (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .dsp_resume_signal,
        .dsp_irq, .ext_irq, .debug_port_rst, .tdm_ext_clk_pin, .prog_rom_location_select,
        .dsp_addr, .dsp_prog_space, .dsp_movp_rd, .clk_ctl, .dsp_mode, .dsp_regs_keep,
        .dsp_soft_rst, .cpu_clk_en, .tdm_clk_en, .dec_mmr_sel, .dec_mmr_block, .dec_emu_sel,
        .dec_app_rom_onchip, .dec_app_rom_offchip, .dec_prom_block);
    dpc_cpu_model dpc_cpu_model_inst (.clk_sys, .rst_n, .res_go, .res_dly, .dsp_mode,
        .dsp_resume_signal);
    // ********************************
    // helpers
    // ********************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [4:0] exp_dec(input logic [15:0] a, input logic pr, input logic m,
        input logic s);
        logic app;
        app = pr && a >= DPC_APP_LO && a <= DPC_APP_HI;
        return {pr && m && a <= DPC_PROM_HI, !pr && a >= DPC_MMR_LO && a <= DPC_MMR_HI,
            !pr && a >= DPC_EMU_LO && a <= DPC_EMU_HI, app && s, app && !s};
    endfunction
    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(n < 20, 1'b1)
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        while (dsp_mode !== m && n < 100) begin
            @(posedge clk_sys);
            n++;
        end
        `CHK(dsp_mode, m)
    endtask
    // spacing between two enable pulses, measured from the second pulse seen
    task automatic per(input bit t);
        int n;
        for (n = 0; n < 2; n++) begin
            p = 0;
            while ((t ? tdm_clk_en : cpu_clk_en) !== 1'b1 && p < 600) begin
                @(posedge clk_sys);
                p++;
            end
            @(posedge clk_sys);
            p = 1;
            while ((t ? tdm_clk_en : cpu_clk_en) !== 1'b1 && p < 600) begin
                @(posedge clk_sys);
                p++;
            end
        end
    endtask
    always @(posedge clk_sys) begin
        cyc_cnt++;
        tdm_cnt += (tdm_clk_en === 1'b1);
        if (cyc_cnt == 20000) begin
            err_total++;
            conclude();
        end
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        wb(0, DPC_REG_STATUS, 0);
        `CHK(q[3:0], 4'h1)
        wb(0, DPC_REG_CLKCFG, 0);
        `CHK(q, DPC_CLKCFG_RST)
        wb(0, 8'h14, 32'hffff_ffff);
        `CHK(q, 32'h0)
        for (i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            v = {18'h0, 2'b01, 3'(i), seed[8], 1'b1, seed[6:2], 2'(i % 3)};
            wb(1, DPC_REG_CLKCFG, v);
            wb(0, DPC_REG_CLKCFG, 0);
            `CHK(q[13:0], v[13:0] & 14'h2fff)
            `CHK({clk_ctl.post_div2, clk_ctl.pll_mul, clk_ctl.pre_div}, v[8:0])
            per(0);
            `CHK(p, 1 << i)
        end
        wb(1, DPC_REG_TDMDIV, {24'h0, 4'h0, seed[3:0]});
        per(1);
        `CHK(p, int'(seed[3:0]) + 1)
        wb(1, DPC_REG_CLKCFG, 32'h2080);
        repeat (5) @(posedge clk_sys);
        tdm_cnt = 0;
        for (i = 0; i < 8; i++) begin
            tdm_ext_clk_pin <= ~tdm_ext_clk_pin;
            repeat (6) @(posedge clk_sys);
        end
        `CHK(tdm_cnt, 4)
        for (i = 0; i < 4; i++) begin
            wb(1, DPC_REG_CTRL, 32'h1);
            wait_mode(DPC_IDLE);
            repeat (6) @(posedge clk_sys);
            `CHK(dsp_mode, DPC_IDLE)
            if (i == 3) begin
                wb(1, DPC_REG_CTRL, 32'h4);
                `CHK(dsp_soft_rst, 1'b1)
            end
            dsp_irq <= (i == 0);
            ext_irq <= (i == 1);
            debug_port_rst <= (i == 2);
            wait_mode(DPC_ACTIVE);
            {dsp_irq, ext_irq, debug_port_rst} <= 3'b000;
            repeat (5) @(posedge clk_sys);
        end
        for (i = 0; i < 3; i++) begin
            wb(1, DPC_REG_CTRL, 32'h2);
            wait_mode(DPC_STOP);
            if (i == 0) begin
                wb(1, DPC_REG_CLKCFG, 32'h1080);
                wb(0, DPC_REG_STATUS, 0);
                `CHK(q[3], 1'b1)
                dsp_irq <= 1'b1;
                repeat (8) @(posedge clk_sys);
                `CHK(dsp_mode, DPC_STOP)
                dsp_irq <= 1'b0;
            end
            res_dly <= 8'(i * 30);
            res_go <= (i != 2);
            ext_irq <= (i == 2);
            @(posedge clk_sys);
            res_go <= 1'b0;
            wait_mode(DPC_ACTIVE);
            ext_irq <= 1'b0;
            @(posedge clk_sys);
            `CHK(dsp_regs_keep, i != 2)
            `CHK(clk_ctl.dsp_clk_en, 1'b0)
            repeat (SETTLE + 4) @(posedge clk_sys);
            `CHK(clk_ctl.dsp_clk_en, 1'b1)
            repeat (4) @(posedge clk_sys);
        end
        for (k = 0; k < 2; k++) begin
            prog_rom_location_select <= !k[0];
            repeat (5) @(posedge clk_sys);
            wb(0, DPC_REG_DECODE, 0);
            `CHK(q[0], !k[0])
            for (j = 0; j < 40; j++) begin
                seed = lfsr(seed);
                a16 = (j < 12) ? corner[j] : seed[15:0];
                v[1:0] = (j < 12) ? {j[0] ^ k[0], 1'b1} : seed[17:16];
                dsp_addr <= a16;
                dsp_prog_space <= v[1];
                dsp_movp_rd <= v[0];
                repeat (2) @(posedge clk_sys);
                `CHK({dec_prom_block, dec_mmr_sel, dec_emu_sel, dec_app_rom_onchip, dec_app_rom_offchip}, exp_dec(a16, v[1], v[0], !k[0]))
            end
        end
        conclude();
    end
endmodule // testbench
bind dpc_top dpc_chk #(.SETTLE_CYC(SETTLE_CYC)) dpc_chk_inst (.clk_sys, .rst_n, .wb_cyc_i,
    .wb_we_i, .wb_adr_i, .wb_ack_o, .dsp_addr, .dsp_prog_space, .dsp_movp_rd, .clk_ctl,
    .dsp_mode, .dec_mmr_sel, .dec_mmr_block, .dec_emu_sel, .dec_app_rom_onchip,
    .dec_app_rom_offchip, .dec_prom_block);
`default_nettype wire
